// file: bench/analog_cmp_model.sv
// Behavioural analog comparator that sits beside the control block.
// Assumes the bench sets the input levels; the bandgap level is a parameter.
`timescale 1ns/100ps
module analog_cmp_model #(
  parameter logic [7:0] BANDGAP = 8'h80
) (
  input  wire logic       clk_i,
  input  wire logic       enable_i,
  input  wire logic       ref_select_i,
  input  wire logic [7:0] plus_level_i,
  input  wire logic [7:0] minus_level_i,
  output logic            out_o
);
  logic flip = 1'b0;
  always @(posedge clk_i) flip <= ~flip;
  // Unpowered output carries no meaning, so it wanders
  always_comb begin
    if (!enable_i) out_o = flip;
    else if (ref_select_i) out_o = BANDGAP > minus_level_i;
    else out_o = plus_level_i > minus_level_i;
  end
endmodule : analog_cmp_model

// file: bench/testbench.sv
// Self-checking bench for the comparator mode control block.
// Assumes analog_cmp_model drives the raw comparator output.
`timescale 1ns/100ps
module testbench;
  logic       clk = 1'b0, rst_b = 1'b0, on = 1'b1, rsel = 1'b0, ien = 1'b1, pen = 1'b1;
  logic       cw = 1'b0, cd = 1'b0, route = 1'b0, tpin = 1'b0;
  logic       aout, aen, asel, flag, res, irq, pin, oe, cap, usable;
  logic [1:0] mode = 2'h0, esel = 2'h0;
  logic [7:0] plus = 8'h00, minus = 8'h80;
  int         n_mismatch = 0, num_checks = 0;
  // Rows: edge select, power mode, rising step, flag expected
  logic [5:0] rows [8] = '{6'h02, 6'h01, 6'h17, 6'h18, 6'h21, 6'h26, 6'h3b, 6'h31};

  analog_cmp_model analog_cmp_model_inst (.clk_i(clk), .enable_i(aen), .ref_select_i(asel),
    .plus_level_i(plus), .minus_level_i(minus), .out_o(aout));
  comparator_mode_control comparator_mode_control_inst (.clk_i(clk), .rst_b_i(rst_b),
    .power_mode_i(mode), .comparator_on_i(on), .ref_input_select_i(rsel),
    .compare_irq_enable_i(ien), .result_pin_enable_i(pen), .edge_select_i(esel),
    .flag_clear_write_i(cw), .flag_clear_data_i(cd), .capture_route_i(route),
    .analog_out_i(aout), .timer_one_chan0_pin_i(tpin), .analog_enable_o(aen),
    .analog_ref_select_o(asel), .compare_flag_o(flag), .compare_result_bit_o(res),
    .irq_o(irq), .result_pin_o(pin), .result_pin_oe_o(oe),
    .timer_one_chan0_capture_o(cap), .timer_one_chan0_pin_usable_o(usable));

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic clr(input logic d);
    cw = 1'b1;
    cd = d;
    step(1);
    cw = 1'b0;
  endtask : clr

  task automatic chk(input string name, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    step(10);
    rst_b = 1'b1;
    step(3);
    for (int i = 0; i < 8; i++) begin
      {esel, mode} = rows[i][5:2];
      route = i[0];
      tpin = ~rows[i][1];
      plus = rows[i][1] ? 8'h00 : 8'hff;
      step(6);
      clr(1'b1);
      step(2);
      plus = ~plus;
      step(6);
      chk("flag", flag, rows[i][0]);
      chk("irq", irq, rows[i][0]);
      chk("result", res, rows[i][1]);
      chk("pin", pin & oe, rows[i][1]);
      chk("capture", cap, route ? rows[i][1] : tpin);
      chk("usable", usable, ~route);
    end
    ien = 1'b0;
    step(1);
    chk("irq_off", irq, 1'b0);
    clr(1'b0);
    step(1);
    chk("keep", flag, 1'b1);
    clr(1'b1);
    step(1);
    chk("cleared", flag, 1'b0);
    plus = 8'hff;
    step(2);
    clr(1'b1);
    chk("set_wins", flag, 1'b1);
    step(3);
    on = 1'b0;
    mode = cmp_ctrl_pkg::PWR_WAIT;
    step(2);
    chk("off_res", res, 1'b0);
    chk("off_oe", oe, 1'b0);
    chk("wait_off", aen, 1'b0);
    on = 1'b1;
    mode = cmp_ctrl_pkg::PWR_RUN;
    rsel = 1'b1;
    minus = 8'h40;
    step(6);
    chk("bg_sel", asel, 1'b1);
    chk("bg_hi", res, 1'b1);
    minus = 8'hc0;
    step(6);
    chk("bg_lo", res, 1'b0);
    mode = cmp_ctrl_pkg::PWR_DEEP;
    step(3);
    chk("deep_flag", flag, 1'b0);
    chk("deep_on", aen, 1'b0);
    mode = cmp_ctrl_pkg::PWR_STOP3;
    rsel = 1'b0;
    minus = 8'h80;
    step(6);
    chk("stop3_set", flag, 1'b1);
    rst_b = 1'b0;
    step(1);
    chk("rst_flag", flag, 1'b0);
    chk("rst_res", res, 1'b0);
    wrap_up();
  end
endmodule : testbench

// file: hw/cmp_ctrl_pkg.sv
// Constants for the comparator mode control block.
// Assumes a single bus clock; no register bus, control bits are ports.
package cmp_ctrl_pkg;
  // Edge select encodings
  localparam logic [1:0] EDGE_FALL0 = 2'h0;
  localparam logic [1:0] EDGE_RISE  = 2'h1;
  localparam logic [1:0] EDGE_FALL2 = 2'h2;
  localparam logic [1:0] EDGE_BOTH  = 2'h3;
  // Low power mode encodings
  localparam logic [1:0] PWR_RUN   = 2'h0;
  localparam logic [1:0] PWR_WAIT  = 2'h1;
  localparam logic [1:0] PWR_STOP3 = 2'h2;
  localparam logic [1:0] PWR_DEEP  = 2'h3;
  // Reset values
  localparam logic       FLAG_RST   = 1'h0;
  localparam logic       RESULT_RST = 1'h0;
  localparam logic [1:0] SYNC_RST   = 2'h0;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage : cmp_ctrl_pkg

// file: hw/comparator_mode_control.sv
// Digital wrapper around an analog comparator: input select, edge flag,
// wake request, result pin and timer capture routing.
// Assumes the analog comparator output is asynchronous to clk_i.
//
// Behaviour
// [R1] Comparisons and edge detection continue in stop3 when enabled.
// [R2] In stop3 the result pin is driven as in run when enabled.
// [R3] Compare event in stop sets the flag and requests wake if irq enabled.
// [R4] Reset exit from stop returns all control and status to reset values.
// [R5] Stop2/stop1 power the block off; wake-up leaves it in reset state.
// [R6] Enabled before wait, the comparator keeps running through wait.
// [R7] In wait, a flagged event with irq enable gives a wake interrupt.
// [R8] Software should disable the comparator in wait unless needed.
// [R9] Background debug halt changes nothing in comparator behaviour.
// [R10] Capture route set feeds the result to timer one channel 0.
// [R11] Capture route set makes timer one channel 0 pin unavailable.
// [R12] Software choosing bandgap must also turn on the bandgap buffer.
// [R13] Event is selectable as rising, falling or either edge.
// [R14] A select replaces the external plus input with the bandgap.
// [R15] The result can be shown on a dedicated output pin.
// [R16] Edge select: 00 fall, 01 rise, 10 fall, 11 either edge.
// [R17] Flag clears only on write of one; zero leaves it.
// [R18] Result bit resets to 0 and reads 0 while disabled.
// [R19] Interrupt request asserts while flag and irq enable are both set.
// [R20] The analog output passes a two-stage synchroniser before use.
`timescale 1ns/100ps
module comparator_mode_control (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [1:0] power_mode_i,
  input  wire logic       comparator_on_i,
  input  wire logic       ref_input_select_i,
  input  wire logic       compare_irq_enable_i,
  input  wire logic       result_pin_enable_i,
  input  wire logic [1:0] edge_select_i,
  input  wire logic       flag_clear_write_i,
  input  wire logic       flag_clear_data_i,
  input  wire logic       capture_route_i,
  input  wire logic       analog_out_i,
  input  wire logic       timer_one_chan0_pin_i,
  output logic            analog_enable_o,
  output logic            analog_ref_select_o,
  output logic            compare_flag_o,
  output logic            compare_result_bit_o,
  output logic            irq_o,
  output logic            result_pin_o,
  output logic            result_pin_oe_o,
  output logic            timer_one_chan0_capture_o,
  output logic            timer_one_chan0_pin_usable_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_b = rst_pipe[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
    logic       flag;
    logic       result;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    unique case (sel)
      cmp_ctrl_pkg::EDGE_FALL0: edge_hit = fall;
      cmp_ctrl_pkg::EDGE_RISE:  edge_hit = rise;
      cmp_ctrl_pkg::EDGE_FALL2: edge_hit = fall;
      cmp_ctrl_pkg::EDGE_BOTH:  edge_hit = rise | fall;
    endcase
  endfunction : edge_hit

  logic deep_off;
  logic active;
  logic rise;
  logic fall;
  logic event_hit;

  // Deep stop: powered off, held at reset state
  assign deep_off = (power_mode_i == cmp_ctrl_pkg::PWR_DEEP); // R5
  // Run, wait, stop3 and debug halt all behave alike
  assign active   = comparator_on_i & ~deep_off; // R1 R6 R9
  assign rise     = st.sync[1] & ~st.prev;
  assign fall     = ~st.sync[1] & st.prev;
  assign event_hit = active & edge_hit(edge_select_i, rise, fall); // R13 R16

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (deep_off) begin
      next_st.sync   = cmp_ctrl_pkg::SYNC_RST; // R5
      next_st.prev   = cmp_ctrl_pkg::RESULT_RST;
      next_st.flag   = cmp_ctrl_pkg::FLAG_RST;
      next_st.result = cmp_ctrl_pkg::RESULT_RST;
    end else if (!comparator_on_i) begin
      next_st.sync   = cmp_ctrl_pkg::SYNC_RST;
      next_st.prev   = cmp_ctrl_pkg::RESULT_RST;
      next_st.result = cmp_ctrl_pkg::RESULT_RST; // R18
      if (flag_clear_write_i && flag_clear_data_i) begin
        next_st.flag = cmp_ctrl_pkg::FLAG_RST; // R17
      end
    end else begin
      next_st.sync   = {st.sync[0], analog_out_i}; // R20
      next_st.prev   = st.sync[1];
      next_st.result = st.sync[1];
      // Set wins over a simultaneous clear
      if (event_hit) begin
        next_st.flag = 1'h1; // R3
      end else if (flag_clear_write_i && flag_clear_data_i) begin
        next_st.flag = cmp_ctrl_pkg::FLAG_RST; // R17
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0; // R4
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign analog_enable_o      = active;
  assign analog_ref_select_o  = ref_input_select_i; // R14
  assign compare_flag_o       = st.flag;
  assign compare_result_bit_o = st.result; // R18
  assign irq_o                = st.flag & compare_irq_enable_i; // R19 R7 R3
  assign result_pin_o         = st.result; // R15 R2
  assign result_pin_oe_o      = result_pin_enable_i & active; // R2
  assign timer_one_chan0_capture_o = capture_route_i ? st.result
                                                     : timer_one_chan0_pin_i; // R10
  assign timer_one_chan0_pin_usable_o = ~capture_route_i; // R11

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b);

  chk_irq_follows_flag: assert property ( // R19
    event_hit |=> (irq_o == compare_irq_enable_i))
    else $error("irq not raised with flag");
  chk_result_zero_off: assert property ( // R18
    !comparator_on_i |=> !compare_result_bit_o)
    else $error("result bit not zero while disabled");
  chk_rise_sets_flag: assert property ( // R13
    (active && edge_select_i == cmp_ctrl_pkg::EDGE_RISE && rise) |=> compare_flag_o)
    else $error("rising edge did not set flag");
  chk_fall_sets_flag: assert property ( // R16
    (active && edge_select_i == cmp_ctrl_pkg::EDGE_FALL2 && fall) |=> compare_flag_o)
    else $error("falling edge did not set flag");
  chk_zero_write_keeps: assert property ( // R17
    (compare_flag_o && !(flag_clear_write_i && flag_clear_data_i) && !deep_off)
      |=> compare_flag_o)
    else $error("flag lost without clear");
  chk_one_write_clears: assert property ( // R17
    (flag_clear_write_i && flag_clear_data_i && !event_hit) |=> !compare_flag_o)
    else $error("flag not cleared by one");
  chk_deep_off_reset: assert property ( // R5
    deep_off |-> (!result_pin_oe_o && !analog_enable_o)
      ##1 (!compare_flag_o && !compare_result_bit_o))
    else $error("state not reset in deep stop");
  chk_stop3_runs: assert property ( // R1
    (power_mode_i == cmp_ctrl_pkg::PWR_STOP3 && comparator_on_i) ##1
    (power_mode_i == cmp_ctrl_pkg::PWR_STOP3 && comparator_on_i)
      |-> compare_result_bit_o == $past(st.sync[1]))
    else $error("comparator stalled in stop3");
  chk_capture_route: assert property ( // R10
    capture_route_i |-> (timer_one_chan0_capture_o == compare_result_bit_o
                         && !timer_one_chan0_pin_usable_o))
    else $error("capture routing wrong");
  chk_sync_delay: assert property ( // R20
    (active ##1 active ##1 active) |-> st.sync[1] == $past(analog_out_i, 2))
    else $error("synchroniser depth wrong");
  chk_set_wins: assert property ( // R3
    (event_hit && flag_clear_write_i && flag_clear_data_i) |=> compare_flag_o)
    else $error("clear beat a compare event");
  chk_stop3_wakes: assert property ( // R3
    (power_mode_i == cmp_ctrl_pkg::PWR_STOP3 && event_hit)
      |=> (irq_o || !compare_irq_enable_i))
    else $error("no wake request in stop3");
  chk_wait_wakes: assert property ( // R7
    (power_mode_i == cmp_ctrl_pkg::PWR_WAIT && event_hit)
      |=> (irq_o || !compare_irq_enable_i))
    else $error("no wake request in wait");
  chk_wait_runs: assert property ( // R6
    (power_mode_i == cmp_ctrl_pkg::PWR_WAIT && comparator_on_i) ##1
    (power_mode_i == cmp_ctrl_pkg::PWR_WAIT && comparator_on_i)
      |-> compare_result_bit_o == $past(st.sync[1]))
    else $error("comparator stalled in wait");
  chk_stop3_pin: assert property ( // R2
    (power_mode_i == cmp_ctrl_pkg::PWR_STOP3 && comparator_on_i && result_pin_enable_i)
      |-> (result_pin_oe_o && result_pin_o == compare_result_bit_o))
    else $error("result pin idle in stop3");
  chk_route_off: assert property ( // R11
    !capture_route_i |-> (timer_one_chan0_capture_o == timer_one_chan0_pin_i
                          && timer_one_chan0_pin_usable_o))
    else $error("timer pin not restored");
  chk_off_no_set: assert property ( // R5
    (!active && !compare_flag_o) |=> !compare_flag_o)
    else $error("flag set while powered off");

  cov_wake_stop3: cover property (
    power_mode_i == cmp_ctrl_pkg::PWR_STOP3 && event_hit && compare_irq_enable_i);
  cov_wake_wait: cover property (
    power_mode_i == cmp_ctrl_pkg::PWR_WAIT && irq_o);
  cov_both_edges: cover property (
    edge_select_i == cmp_ctrl_pkg::EDGE_BOTH && event_hit);
  cov_set_and_clear: cover property (
    event_hit && flag_clear_write_i && flag_clear_data_i);

endmodule : comparator_mode_control
